// *** rtl/flag_test_pkg.sv ***
// Constants shared by the flag-test skip decoder and its testbench.
// Assumes a 10-bit instruction word and a 32-bit APB register bus.
package flag_test_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CODE_W    = 10;
    localparam int unsigned CTRL_W    = 4;
    localparam int unsigned COUNT_W   = 16;
    localparam int unsigned NUM_TESTS = 4;

    // ==========================================================
    // Instruction codes
    localparam logic [CODE_W-1:0] OP_TIMER_ONE   = 10'h280;
    localparam logic [CODE_W-1:0] OP_TIMER_TWO   = 10'h281;
    localparam logic [CODE_W-1:0] OP_TIMER_THREE = 10'h282;
    localparam logic [CODE_W-1:0] OP_VOLT_DROP   = 10'h28A;
    localparam logic [NUM_TESTS-1:0][CODE_W-1:0] TEST_OPCODES =
        {OP_VOLT_DROP, OP_TIMER_THREE, OP_TIMER_TWO, OP_TIMER_ONE};

    // ==========================================================
    // Unit index per test
    localparam int unsigned FT_ONE   = 0;
    localparam int unsigned FT_TWO   = 1;
    localparam int unsigned FT_THREE = 2;
    localparam int unsigned FT_VDROP = 3;

    // ==========================================================
    // Enable bit positions in the interrupt-control registers
    localparam int unsigned TIMER_ONE_EN_BIT   = 2;
    localparam int unsigned TIMER_TWO_EN_BIT   = 3;
    localparam int unsigned TIMER_THREE_EN_BIT = 0;
    localparam int unsigned VOLT_DROP_EN_BIT   = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SKIPS    = 8'h14;

    // ==========================================================
    // Reset values
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 4'h0;
    localparam logic [CTRL_W-1:0]  MASK_RST  = 4'h0;
    localparam logic [CTRL_W-1:0]  STAT_RST  = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0]  RDATA_RST = 32'h00000000;

    // ==========================================================
    // Status bit positions
    localparam int unsigned ST_SKIP      = 0;
    localparam int unsigned ST_SUPPRESS  = 1;
    localparam int unsigned ST_TIMER_SET = 2;
    localparam int unsigned ST_VDROP     = 3;

    // ==========================================================
    // Bus slave phases
    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_ANSWER = 2'b01
    } apb_state_e;

endpackage

// *** rtl/flag_test_if.sv ***
// Signals between the decoder and one request-flag unit.
// Assumes the decoder drives hit only for a live, unsuppressed fetch.
`timescale 1ns/1ps
interface flag_test_if;
    logic set_evt;
    logic sw_clear;
    logic hit;
    logic masked;
    logic flag;
    logic skip;

    modport unit (input set_evt, input sw_clear, input hit, input masked,
                  output flag, output skip);
    modport ctrl (output set_evt, output sw_clear, output hit, output masked,
                  input flag, input skip);
endinterface

// *** rtl/flag_tester.sv ***
// One request flag with its conditional-skip test.
// Assumes set_evt is a one-cycle pulse, or a level when CLEARS is 0.
`timescale 1ns/1ps
module flag_tester #(
    parameter bit CLEARS = 1'b1
) (
    // Clock and reset
    input wire logic     pclk,
    input wire logic     presetn,
    // Decoder side
    flag_test_if.unit    port
);

    typedef struct packed {
        logic flag;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ==========================================================
    // Test and flag update
    assign port.flag = st_q.flag;
    // Enable bit high turns the test into a no-operation
    assign port.skip = port.hit & ~port.masked & st_q.flag;

    always_comb begin
        st_d = st_q;
        if (CLEARS) begin
            // Set wins over any clear in the same cycle
            st_d.flag = (st_q.flag & ~port.skip & ~port.sw_clear) | port.set_evt;
        end else begin
            // Level follower; the test never clears it
            st_d.flag = port.set_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// *** rtl/flag_test_skip_instructions.sv ***
// Decoder and skip control for the four flag-test instructions.
// Assumes one instruction per instr_valid cycle; core honours skip_next_q.
`timescale 1ns/1ps
module flag_test_skip_instructions (
    // Clock and reset
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    // APB slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [flag_test_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [flag_test_pkg::DATA_W-1:0]    pwdata,
    output logic      [flag_test_pkg::DATA_W-1:0]    prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // Instruction stream
    input  wire logic                                instr_valid,
    input  wire logic [flag_test_pkg::CODE_W-1:0]    instr_code,
    // Flag sources
    input  wire logic                                timer_one_set,
    input  wire logic                                timer_two_set,
    input  wire logic                                timer_three_set,
    input  wire logic                                voltage_drop_in,
    // Skip control
    output logic                                     skip_next_q,
    output logic                                     skip_taken_q,
    output logic                                     suppressed_q,
    // Flags
    output logic                                     timer_one_request_flag,
    output logic                                     timer_two_request_flag,
    output logic                                     timer_three_request_flag,
    output logic                                     voltage_drop_flag,
    // Interrupt
    output logic                                     irq_q
);

    // ==========================================================
    // State
    typedef struct packed {
        flag_test_pkg::apb_state_e                   apb;
        logic [flag_test_pkg::DATA_W-1:0]            rdata;
        logic                                        ready;
        logic                                        slverr;
        logic [flag_test_pkg::CTRL_W-1:0]            ctrl_one;
        logic [flag_test_pkg::CTRL_W-1:0]            ctrl_two;
        logic [flag_test_pkg::CTRL_W-1:0]            status;
        logic [flag_test_pkg::CTRL_W-1:0]            mask;
        logic [flag_test_pkg::COUNT_W-1:0]           skips;
        logic                                        skip_next;
        logic                                        skip_taken;
        logic                                        suppressed;
        logic                                        vd_prev;
        logic                                        irq;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ==========================================================
    // Flag units
    logic [flag_test_pkg::NUM_TESTS-1:0]             set_vec;
    logic [flag_test_pkg::NUM_TESTS-1:0]             clr_vec;
    logic [flag_test_pkg::NUM_TESTS-1:0]             hit_vec;
    logic [flag_test_pkg::NUM_TESTS-1:0]             mask_vec;
    logic [flag_test_pkg::NUM_TESTS-1:0]             flag_vec;
    logic [flag_test_pkg::NUM_TESTS-1:0]             skip_vec;

    flag_test_if ft [flag_test_pkg::NUM_TESTS] ();

    assign set_vec[flag_test_pkg::FT_ONE]   = timer_one_set;
    assign set_vec[flag_test_pkg::FT_TWO]   = timer_two_set;
    assign set_vec[flag_test_pkg::FT_THREE] = timer_three_set;
    assign set_vec[flag_test_pkg::FT_VDROP] = voltage_drop_in;

    genvar g;
    generate
        for (g = 0; g < flag_test_pkg::NUM_TESTS; g++) begin : gen_test
            assign ft[g].set_evt  = set_vec[g];
            assign ft[g].sw_clear = clr_vec[g];
            assign ft[g].hit      = hit_vec[g];
            assign ft[g].masked   = mask_vec[g];
            assign flag_vec[g]    = ft[g].flag;
            assign skip_vec[g]    = ft[g].skip;

            // Voltage-drop unit only follows the detector
            flag_tester #(
                .CLEARS (g != flag_test_pkg::FT_VDROP)
            ) u_test (
                .pclk    (pclk),
                .presetn (presetn),
                .port    (ft[g].unit)
            );
        end
    endgenerate

    // ==========================================================
    // Decode
    logic fetch_live;
    logic any_skip;

    // A suppressed word can neither test nor clear a flag
    assign fetch_live = instr_valid & ~st_q.skip_next;

    always_comb begin
        for (int i = 0; i < flag_test_pkg::NUM_TESTS; i++) begin
            // Exact 10-bit match; carry is never driven here
            hit_vec[i] = fetch_live
                       & (instr_code == flag_test_pkg::TEST_OPCODES[i]);
        end
    end

    always_comb begin
        mask_vec[flag_test_pkg::FT_ONE] =
            st_q.ctrl_one[flag_test_pkg::TIMER_ONE_EN_BIT];
        mask_vec[flag_test_pkg::FT_TWO] =
            st_q.ctrl_one[flag_test_pkg::TIMER_TWO_EN_BIT];
        mask_vec[flag_test_pkg::FT_THREE] =
            st_q.ctrl_two[flag_test_pkg::TIMER_THREE_EN_BIT];
        mask_vec[flag_test_pkg::FT_VDROP] =
            st_q.ctrl_two[flag_test_pkg::VOLT_DROP_EN_BIT];
    end

    assign any_skip = |skip_vec;

    // ==========================================================
    // Bus decode
    logic                              setup_phase;
    logic                              access_done;
    logic                              wr_done;
    logic                              rd_done;
    logic [flag_test_pkg::DATA_W-1:0]  rd_mux;
    logic                              rd_bad;

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & st_q.ready;
    assign wr_done     = access_done & pwrite & ~st_q.slverr;
    assign rd_done     = access_done & ~pwrite & ~st_q.slverr;

    always_comb begin
        rd_mux = flag_test_pkg::RDATA_RST;
        rd_bad = 1'b0;
        case (paddr)
            flag_test_pkg::OFS_CTRL_ONE: begin
                rd_mux[flag_test_pkg::CTRL_W-1:0] = st_q.ctrl_one;
            end
            flag_test_pkg::OFS_CTRL_TWO: begin
                rd_mux[flag_test_pkg::CTRL_W-1:0] = st_q.ctrl_two;
            end
            flag_test_pkg::OFS_FLAGS: begin
                rd_mux[flag_test_pkg::NUM_TESTS-1:0] = flag_vec;
            end
            flag_test_pkg::OFS_STATUS: begin
                rd_mux[flag_test_pkg::CTRL_W-1:0] = st_q.status;
            end
            flag_test_pkg::OFS_MASK: begin
                rd_mux[flag_test_pkg::CTRL_W-1:0] = st_q.mask;
            end
            flag_test_pkg::OFS_SKIPS: begin
                rd_mux[flag_test_pkg::COUNT_W-1:0] = st_q.skips;
            end
            default: begin
                rd_bad = 1'b1;
            end
        endcase
    end

    // Software clear of timer flags; detector flag is read only
    always_comb begin
        clr_vec = '0;
        if (wr_done && paddr == flag_test_pkg::OFS_FLAGS) begin
            clr_vec[flag_test_pkg::FT_ONE]   = pwdata[flag_test_pkg::FT_ONE];
            clr_vec[flag_test_pkg::FT_TWO]   = pwdata[flag_test_pkg::FT_TWO];
            clr_vec[flag_test_pkg::FT_THREE] = pwdata[flag_test_pkg::FT_THREE];
        end
    end

    // ==========================================================
    // Next state
    logic [flag_test_pkg::CTRL_W-1:0] events;
    logic [flag_test_pkg::CTRL_W-1:0] rd_clear;

    always_comb begin
        st_d = st_q;

        // Skip sequencing
        st_d.skip_taken = 1'b0;
        st_d.suppressed = 1'b0;
        if (instr_valid) begin
            if (st_q.skip_next) begin
                // Fetched but killed; next word runs normally
                st_d.skip_next  = 1'b0;
                st_d.suppressed = 1'b1;
            end else begin
                st_d.skip_next  = any_skip;
                st_d.skip_taken = any_skip;
            end
        end

        // Events
        st_d.vd_prev = flag_vec[flag_test_pkg::FT_VDROP];
        events = '0;
        events[flag_test_pkg::ST_SKIP]      = st_d.skip_taken;
        events[flag_test_pkg::ST_SUPPRESS]  = st_d.suppressed;
        events[flag_test_pkg::ST_TIMER_SET] = |set_vec[flag_test_pkg::FT_THREE:0];
        events[flag_test_pkg::ST_VDROP]     =
            flag_vec[flag_test_pkg::FT_VDROP] & ~st_q.vd_prev;

        // Read clears only bits that were returned
        rd_clear = '0;
        if (rd_done && paddr == flag_test_pkg::OFS_STATUS) begin
            rd_clear = st_q.rdata[flag_test_pkg::CTRL_W-1:0];
        end
        // Set wins over the read clear
        st_d.status = (st_q.status & ~rd_clear) | events;

        if (st_d.skip_taken) begin
            st_d.skips = st_q.skips + 16'h0001;
        end

        // Bus slave
        case (st_q.apb)
            flag_test_pkg::APB_IDLE: begin
                st_d.ready = 1'b0;
                if (setup_phase) begin
                    // Answer one cycle after setup: no wait beyond that
                    st_d.apb    = flag_test_pkg::APB_ANSWER;
                    st_d.ready  = 1'b1;
                    st_d.slverr = rd_bad;
                    st_d.rdata  = pwrite ? flag_test_pkg::RDATA_RST : rd_mux;
                end
            end
            flag_test_pkg::APB_ANSWER: begin
                if (access_done || !psel) begin
                    st_d.apb    = flag_test_pkg::APB_IDLE;
                    st_d.ready  = 1'b0;
                    st_d.slverr = 1'b0;
                end
                if (wr_done) begin
                    case (paddr)
                        flag_test_pkg::OFS_CTRL_ONE: begin
                            st_d.ctrl_one = pwdata[flag_test_pkg::CTRL_W-1:0];
                        end
                        flag_test_pkg::OFS_CTRL_TWO: begin
                            st_d.ctrl_two = pwdata[flag_test_pkg::CTRL_W-1:0];
                        end
                        flag_test_pkg::OFS_MASK: begin
                            st_d.mask = pwdata[flag_test_pkg::CTRL_W-1:0];
                        end
                        flag_test_pkg::OFS_SKIPS: begin
                            st_d.skips = flag_test_pkg::COUNT_RST;
                        end
                        default: begin
                            st_d.mask = st_d.mask;
                        end
                    endcase
                end
            end
            default: begin
                st_d.apb   = flag_test_pkg::APB_IDLE;
                st_d.ready = 1'b0;
            end
        endcase

        st_d.irq = |(st_d.status & st_d.mask);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.apb        <= flag_test_pkg::APB_IDLE;
            st_q.rdata      <= flag_test_pkg::RDATA_RST;
            st_q.ready      <= 1'b0;
            st_q.slverr     <= 1'b0;
            st_q.ctrl_one   <= flag_test_pkg::CTRL_RST;
            st_q.ctrl_two   <= flag_test_pkg::CTRL_RST;
            st_q.status     <= flag_test_pkg::STAT_RST;
            st_q.mask       <= flag_test_pkg::MASK_RST;
            st_q.skips      <= flag_test_pkg::COUNT_RST;
            st_q.skip_next  <= 1'b0;
            st_q.skip_taken <= 1'b0;
            st_q.suppressed <= 1'b0;
            st_q.vd_prev    <= 1'b0;
            st_q.irq        <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata                   = st_q.rdata;
    assign pready                   = st_q.ready;
    assign pslverr                  = st_q.slverr;
    assign skip_next_q              = st_q.skip_next;
    assign skip_taken_q             = st_q.skip_taken;
    assign suppressed_q             = st_q.suppressed;
    assign irq_q                    = st_q.irq;
    assign timer_one_request_flag   = flag_vec[flag_test_pkg::FT_ONE];
    assign timer_two_request_flag   = flag_vec[flag_test_pkg::FT_TWO];
    assign timer_three_request_flag = flag_vec[flag_test_pkg::FT_THREE];
    assign voltage_drop_flag        = flag_vec[flag_test_pkg::FT_VDROP];

endmodule

// *** test/flag_test_sva.sv ***
// Checker for the flag-test skip decoder.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flag_test_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Instructions
    input wire logic        instr_valid,
    input wire logic [9:0]  instr_code,
    // Flag sources
    input wire logic        timer_one_set,
    // Results
    input wire logic        skip_next_q,
    input wire logic        skip_taken_q,
    input wire logic        suppressed_q,
    input wire logic        timer_one_request_flag,
    input wire logic        timer_two_request_flag,
    input wire logic        timer_three_request_flag,
    input wire logic        voltage_drop_flag
);
    // ==========================================
    // Control mirror, rebuilt from bus writes
    logic [3:0] c1_q;
    logic [3:0] c2_q;
    logic       wr;
    logic       go;
    assign wr = psel && penable && pready && pwrite;
    assign go = instr_valid && !skip_next_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 4'h0;
            c2_q <= 4'h0;
        end else if (wr && paddr == 8'h00) begin
            c1_q <= pwdata[3:0];
        end else if (wr && paddr == 8'h04) begin
            c2_q <= pwdata[3:0];
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_skip;
        skip_next_q && skip_taken_q;
    endsequence
    sequence s_nop;
        !skip_next_q && !skip_taken_q;
    endsequence
    property p_t1_skip;
        go && instr_code == 10'h280 && !c1_q[2] && timer_one_request_flag
            |=> s_skip ##0 (timer_one_request_flag == $past(timer_one_set));
    endproperty
    property p_t1_nop;
        go && instr_code == 10'h280 && c1_q[2]
            |=> s_nop ##0 (timer_one_request_flag || !$past(timer_one_request_flag));
    endproperty
    property p_t2_skip;
        go && instr_code == 10'h281 && !c1_q[3] && timer_two_request_flag |=> s_skip;
    endproperty
    property p_t2_nop;
        go && instr_code == 10'h281 && c1_q[3]
            |=> s_nop ##0 (timer_two_request_flag || !$past(timer_two_request_flag));
    endproperty
    property p_t3_skip;
        go && !c2_q[0] && timer_three_request_flag && instr_code == 10'h282 |=> s_skip;
    endproperty
    property p_t3_nop;
        go && instr_code == 10'h282 && c2_q[0] |=> s_nop;
    endproperty
    property p_vd_skip;
        go && instr_code == 10'h28A && !c2_q[3] && voltage_drop_flag |=> s_skip;
    endproperty
    property p_suppress;
        instr_valid && skip_next_q |=> suppressed_q && !skip_next_q && !skip_taken_q;
    endproperty
    a_t1_skip: assert property (p_t1_skip) else $error("t1 skip wrong");
    a_t1_nop: assert property (p_t1_nop) else $error("t1 nop wrong");
    a_t2_skip: assert property (p_t2_skip) else $error("t2 skip wrong");
    a_t2_nop: assert property (p_t2_nop) else $error("t2 nop wrong");
    a_t3_skip: assert property (p_t3_skip) else $error("t3 skip wrong");
    a_t3_nop: assert property (p_t3_nop) else $error("t3 nop wrong");
    a_vd_skip: assert property (p_vd_skip) else $error("vd skip wrong");
    a_suppress: assert property (p_suppress) else $error("no suppress");
endmodule

bind flag_test_skip_instructions flag_test_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
    .instr_valid(instr_valid), .instr_code(instr_code), .timer_one_set(timer_one_set),
    .skip_next_q(skip_next_q), .skip_taken_q(skip_taken_q),
    .suppressed_q(suppressed_q), .timer_one_request_flag(timer_one_request_flag),
    .timer_two_request_flag(timer_two_request_flag),
    .timer_three_request_flag(timer_three_request_flag),
    .voltage_drop_flag(voltage_drop_flag)
);

// *** test/tb_top.sv ***
// Self-checking bench for the flag-test skip decoder.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, instr_valid;
    logic [9:0]  instr_code;
    logic [2:0]  tset;
    logic        vd_in, skip_q, taken_q, supp_q, irq_q;
    logic [3:0]  flg;
    logic [31:0] cv [3] = '{32'h4, 32'h8, 32'h1};
    int          n_errors, compares;

    flag_test_skip_instructions DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
        .instr_code(instr_code), .timer_one_set(tset[0]), .timer_two_set(tset[1]),
        .timer_three_set(tset[2]), .voltage_drop_in(vd_in), .skip_next_q(skip_q),
        .skip_taken_q(taken_q), .suppressed_q(supp_q),
        .timer_one_request_flag(flg[0]), .timer_two_request_flag(flg[1]),
        .timer_three_request_flag(flg[2]), .voltage_drop_flag(flg[3]), .irq_q(irq_q)
    );

    // ==========================================
    // Tasks
    task automatic summarize();
        $display("Compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        if (!pready) begin
            n_errors++;
            $display("Error pready expected 1 seen 0");
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ins(input logic [9:0] c);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_code <= c;
        @(posedge pclk);
        instr_valid <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic pulse(input int t);
        @(posedge pclk);
        tset[t] <= 1'b1;
        @(posedge pclk);
        tset[t] <= 1'b0;
    endtask

    // ==========================================
    // Clock and sequence
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, instr_valid, vd_in} = 6'h00;
        {paddr, pwdata, instr_code, tset} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        `CHK("flags", 32'h0, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("pslverr", 1'b1, err)
        for (int t = 0; t < 3; t++) begin
            pulse(t);
            ins(flag_test_pkg::TEST_OPCODES[t]);
            `CHK("skip", 1'b1, skip_q)
            `CHK("flag", 1'b0, flg[t])
            `CHK("taken", 1'b1, taken_q)
            pulse(t);
            ins(flag_test_pkg::TEST_OPCODES[t]);
            `CHK("suppressed", 1'b1, supp_q)
            `CHK("flag kept", 1'b1, flg[t])
            apb(1'b1, (t == 2) ? 8'h04 : 8'h00, cv[t]);
            ins(flag_test_pkg::TEST_OPCODES[t]);
            `CHK("nop skip", 1'b0, skip_q)
            `CHK("nop flag", 1'b1, flg[t])
            apb(1'b1, (t == 2) ? 8'h04 : 8'h00, 32'h0);
            apb(1'b1, 8'h08, cv[0] >> (2 - t));
            ins(flag_test_pkg::TEST_OPCODES[t]);
            `CHK("clear skip", 1'b0, skip_q)
        end
        // Voltage drop: skip without clearing, then disabled and idle cases
        @(posedge pclk);
        vd_in <= 1'b1;
        ins(10'h28B);
        `CHK("near code", 1'b0, skip_q)
        ins(10'h28A);
        `CHK("vd skip", 1'b1, skip_q)
        `CHK("vd flag", 1'b1, flg[3])
        ins(10'h3FF);
        `CHK("vd suppressed", 1'b1, supp_q)
        apb(1'b1, 8'h04, 32'h8);
        ins(10'h28A);
        `CHK("vd off", 1'b0, skip_q)
        apb(1'b1, 8'h04, 32'h0);
        vd_in <= 1'b0;
        ins(10'h28A);
        `CHK("vd clear", 1'b0, skip_q)
        // Counter and interrupt
        apb(1'b0, 8'h14, 32'h0);
        `CHK("skip count", 32'h4, rd)
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("count cleared", 32'h0, rd)
        `CHK("irq masked", 1'b0, irq_q)
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(negedge pclk);
        `CHK("irq", 1'b1, irq_q)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("status", 32'hF, rd)
        repeat (2) @(negedge pclk);
        `CHK("irq cleared", 1'b0, irq_q)
        summarize();
    end
endmodule
